// File: atr_drive_model.sv
// drive-side model measuring the phases of each strobe
`timescale 1ns/1ps
`default_nettype none
module atr_drive_model (
    // clock
    input wire logic ref_clk,
    // drive bus
    input wire logic strobe,
    input wire logic busy,
    // measured lengths in clocks
    output logic [5:0] setupLen,
    output logic [5:0] actLen,
    output logic [5:0] busyLen
);
    logic busyQ;
    // ----------------------------------------
    // phase counters
    // ----------------------------------------
    // setup active whole busy span
    always_ff @(posedge ref_clk) begin
        busyQ <= busy;
        if (busy && !busyQ) begin
            setupLen <= {5'h0, !strobe};
            actLen <= {5'h0, strobe};
            busyLen <= 6'h01;
        end else if (busy) begin
            busyLen <= busyLen + 6'h01;
            if (strobe) begin
                actLen <= actLen + 6'h01;
            end else if (actLen == 6'h00) begin
                setupLen <= setupLen + 6'h01;
            end
        end
    end
endmodule : atr_drive_model
`default_nettype wire

// File: atr_params.svh
// offsets, field positions, reset values and timing counts of the timing bank
`ifndef ATR_PARAMS_SVH
`define ATR_PARAMS_SVH

// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define ATR_IDX_SUBSYS_PRI 8'h2c
`define ATR_IDX_CFG_STATUS 8'h50
`define ATR_IDX_CHAN_CTRL 8'h51
`define ATR_IDX_PM_SETUP 8'h53
`define ATR_IDX_PM_STROBE 8'h54
`define ATR_IDX_PS_SETUP 8'h55
`define ATR_IDX_PS_STROBE 8'h56
`define ATR_IDX_SEC_CTRL 8'h57
`define ATR_IDX_SM_STROBE 8'h58
`define ATR_IDX_RA_LEN 8'h59
`define ATR_IDX_SS_STROBE 8'h5b
`define ATR_IDX_IRQ_MASK 8'h70
`define ATR_IDX_SUBSYS_SHD 8'h8c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ATR_CFG_PRI_IRQ 2
`define ATR_CTRL_PRI_EN 2
`define ATR_CTRL_SEC_EN 3
`define ATR_CTRL_PM_RADIS 6
`define ATR_CTRL_PS_RADIS 7
`define ATR_SEC_SM_RADIS 2
`define ATR_SEC_SS_RADIS 3
`define ATR_SEC_IRQ 4
`define ATR_MASK_PRI 0
`define ATR_MASK_SEC 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ATR_RST_SETUP 2'h2
`define ATR_RST_STROBE 8'h00
`define ATR_RST_RA_LEN 8'h40
`define ATR_RST_CFG 8'h00
`define ATR_RST_CHAN_CTRL 8'hcc
`define ATR_RST_SEC_CTRL 8'h8c
`define ATR_RST_SUBSYS 32'h0000_0000

// ----------------------------------------------------------------
// timing counts in clocks
// ----------------------------------------------------------------
`define ATR_CLK_FIELD_MAX 5'h10
`define ATR_SETUP_00 5'h04
`define ATR_SETUP_01 5'h02
`define ATR_SETUP_10 5'h03
`define ATR_SETUP_11 5'h05

`endif

// File: atr_pkg.sv
// types shared by the ata strobe timing bank
`default_nettype none
package atr_pkg;

    // strobe sequencer phases, gray along idle-setup-active-recovery
    typedef enum logic [1:0] {
        ATR_IDLE = 2'h0,
        ATR_SETUP = 2'h1,
        ATR_ACTIVE = 2'h3,
        ATR_RECOV = 2'h2
    } atr_phase_t;

    // one strobe request toward a channel
    typedef struct packed {
        logic start;
        logic drvSel;  // 0 master, 1 slave
    } atr_req_t;

    // per-channel sequencer state
    typedef struct packed {
        atr_phase_t phase;
        logic [4:0] cnt;
        logic [3:0] act;
        logic [3:0] rec;
        logic strobe;
        logic busy;
    } atr_chan_t;

endpackage : atr_pkg
`default_nettype wire

// File: atr_timing_regs.sv
// register bank and strobe sequencers for a dual-channel ata host port
`timescale 1ns/1ps
`default_nettype none
`include "atr_params.svh"

module atr_timing_regs
    import atr_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    // channel events and requests
    input wire logic priIrqEvent,
    input wire logic secIrqEvent,
    input wire atr_req_t priReq,
    input wire atr_req_t secReq,
    // drive bus strobes
    output logic priStrobe,
    output logic priBusy,
    output logic secStrobe,
    output logic secBusy,
    // configuration toward the data path
    output logic [3:0] readAheadDis,
    output logic [7:0] readAheadLen,
    output logic [1:0] chanEnable,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [31:0] subsys;
        logic [7:0] cfgStatus;
        logic [7:0] chanCtrl;
        logic [1:0] pmSetup;
        logic [7:0] pmStrobe;
        logic [1:0] psSetup;
        logic [7:0] psStrobe;
        logic [7:0] secCtrl;
        logic [7:0] smStrobe;
        logic [7:0] raLen;
        logic [7:0] ssStrobe;
        logic [1:0] irqMask;
        atr_chan_t pri;
        atr_chan_t sec;
        logic [DATA_W-1:0] rdData;
        logic irq;
    } atr_state_t;

    localparam atr_chan_t CHAN_RST = '{
        phase: ATR_IDLE, cnt: 5'h00, act: 4'h0, rec: 4'h0,
        strobe: 1'b0, busy: 1'b0};

    // reset image of the whole bank
    localparam atr_state_t STATE_RST = '{
        subsys: `ATR_RST_SUBSYS,
        cfgStatus: `ATR_RST_CFG,
        chanCtrl: `ATR_RST_CHAN_CTRL,
        pmSetup: `ATR_RST_SETUP,
        pmStrobe: `ATR_RST_STROBE,
        psSetup: `ATR_RST_SETUP,
        psStrobe: `ATR_RST_STROBE,
        secCtrl: `ATR_RST_SEC_CTRL,
        smStrobe: `ATR_RST_STROBE,
        raLen: `ATR_RST_RA_LEN,
        ssStrobe: `ATR_RST_STROBE,
        irqMask: 2'h0,
        pri: CHAN_RST,
        sec: CHAN_RST,
        rdData: '0,
        irq: 1'b0};

    atr_state_t s_q;
    atr_state_t s_d;
    logic [7:0] regIdx;

    // byte address is four times the index, low bits ignored
    assign regIdx = regAddr[9:2];

    // ----------------------------------------------------------------
    // timing decode
    // ----------------------------------------------------------------

    function automatic logic [4:0] activeClks(input logic [3:0] f);
        if (f == 4'h0) begin
            return `ATR_CLK_FIELD_MAX;
        end
        return {1'b0, f};
    endfunction : activeClks

    function automatic logic [4:0] recovClks(input logic [3:0] f);
        if (f == 4'h0) begin
            return `ATR_CLK_FIELD_MAX;
        end
        // 1111 wraps to the shortest recovery of one clock
        if (f == 4'hf) begin
            return 5'h01;
        end
        return {1'b0, f} + 5'h01;
    endfunction : recovClks

    function automatic logic [4:0] setupClks(input logic [1:0] f);
        case (f)
            2'h0: return `ATR_SETUP_00;
            2'h1: return `ATR_SETUP_01;
            2'h2: return `ATR_SETUP_10;
            default: return `ATR_SETUP_11;
        endcase
    endfunction : setupClks

    // one clock of a channel's strobe sequencer
    function automatic atr_chan_t chanStep(
        input atr_chan_t c,
        input atr_req_t req,
        input logic [4:0] setup,
        input logic [7:0] mTim,
        input logic [7:0] sTim
    );
        atr_chan_t n;
        logic [7:0] tim;
        // timing is latched at start, so a register write while
        // a strobe is in flight cannot stretch or cut that strobe
        n = c;
        tim = req.drvSel ? sTim : mTim;
        case (c.phase)
            ATR_IDLE: begin
                if (req.start) begin
                    n.act = tim[7:4];
                    n.rec = tim[3:0];
                    n.phase = ATR_SETUP;
                    n.cnt = setup;
                end
            end
            ATR_SETUP: begin
                if (c.cnt == 5'h01) begin
                    n.phase = ATR_ACTIVE;
                    n.cnt = activeClks(c.act);
                end else begin
                    n.cnt = c.cnt - 5'h01;
                end
            end
            ATR_ACTIVE: begin
                if (c.cnt == 5'h01) begin
                    n.phase = ATR_RECOV;
                    n.cnt = recovClks(c.rec);
                end else begin
                    n.cnt = c.cnt - 5'h01;
                end
            end
            ATR_RECOV: begin
                if (c.cnt == 5'h01) begin
                    n.phase = ATR_IDLE;
                    n.cnt = 5'h00;
                end else begin
                    n.cnt = c.cnt - 5'h01;
                end
            end
            default: begin
                n = CHAN_RST;
            end
        endcase
        // outputs follow the next phase so they leave the flops aligned
        n.strobe = (n.phase == ATR_ACTIVE);
        n.busy = (n.phase != ATR_IDLE);
        return n;
    endfunction : chanStep

    // register read mux, unmapped reads as zero
    function automatic logic [DATA_W-1:0] readReg(
        input atr_state_t s,
        input logic [7:0] idx
    );
        logic [DATA_W-1:0] r;
        // reserved bits read zero; setup registers carry bits 7:6 only
        r = '0;
        case (idx)
            // both subsystem locations read one store
            `ATR_IDX_SUBSYS_PRI: r = s.subsys;
            `ATR_IDX_SUBSYS_SHD: r = s.subsys;
            `ATR_IDX_CFG_STATUS: r[7:0] = s.cfgStatus;
            `ATR_IDX_CHAN_CTRL: r[7:0] = s.chanCtrl;
            `ATR_IDX_PM_SETUP: r[7:6] = s.pmSetup;
            `ATR_IDX_PM_STROBE: r[7:0] = s.pmStrobe;
            `ATR_IDX_PS_SETUP: r[7:6] = s.psSetup;
            `ATR_IDX_PS_STROBE: r[7:0] = s.psStrobe;
            `ATR_IDX_SEC_CTRL: r[7:0] = s.secCtrl;
            `ATR_IDX_SM_STROBE: r[7:0] = s.smStrobe;
            `ATR_IDX_RA_LEN: r[7:0] = s.raLen;
            `ATR_IDX_SS_STROBE: r[7:0] = s.ssStrobe;
            `ATR_IDX_IRQ_MASK: r[1:0] = s.irqMask;
            default: r = '0;
        endcase
        return r;
    endfunction : readReg

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // register writes, events, sequencers and read data
    always_comb begin
        logic [7:0] wb;
        logic [4:0] priSetup;
        logic [4:0] pmClk;
        logic [4:0] psClk;
        logic priClr;
        logic secClr;
        wb = regWrData[7:0];
        priSetup = 5'h00;
        pmClk = 5'h00;
        psClk = 5'h00;
        priClr = 1'b0;
        secClr = 1'b0;
        s_d = s_q;
        if (regWrEn) begin
            case (regIdx)
                // shadow store, written from either location
                `ATR_IDX_SUBSYS_PRI: s_d.subsys = regWrData[31:0];
                // shadow writes land in the same store
                `ATR_IDX_SUBSYS_SHD: s_d.subsys = regWrData[31:0];
                `ATR_IDX_CFG_STATUS: priClr = wb[`ATR_CFG_PRI_IRQ];
                `ATR_IDX_CHAN_CTRL: s_d.chanCtrl = wb & 8'hcc;
                `ATR_IDX_PM_SETUP: s_d.pmSetup = wb[7:6];
                `ATR_IDX_PS_SETUP: s_d.psSetup = wb[7:6];
                // active and recovery nibbles per drive
                `ATR_IDX_PM_STROBE: s_d.pmStrobe = wb;
                `ATR_IDX_PS_STROBE: s_d.psStrobe = wb;
                `ATR_IDX_SM_STROBE: s_d.smStrobe = wb;
                `ATR_IDX_SS_STROBE: s_d.ssStrobe = wb;
                `ATR_IDX_SEC_CTRL: begin
                    s_d.secCtrl[7:6] = wb[7:6];
                    s_d.secCtrl[`ATR_SEC_SM_RADIS] = wb[`ATR_SEC_SM_RADIS];
                    s_d.secCtrl[`ATR_SEC_SS_RADIS] = wb[`ATR_SEC_SS_RADIS];
                    secClr = wb[`ATR_SEC_IRQ];
                end
                `ATR_IDX_RA_LEN: s_d.raLen = wb;
                `ATR_IDX_IRQ_MASK: s_d.irqMask = wb[1:0];
                default: s_d.irqMask = s_q.irqMask;
            endcase
        end
        // an event in the clearing cycle keeps the bit set, so no
        // interrupt is lost between the status read and its clear
        // primary pending, set wins over clear
        s_d.cfgStatus[`ATR_CFG_PRI_IRQ] =
            (s_q.cfgStatus[`ATR_CFG_PRI_IRQ] & ~priClr) | priIrqEvent;
        // secondary pending, set wins over clear
        s_d.secCtrl[`ATR_SEC_IRQ] =
            (s_q.secCtrl[`ATR_SEC_IRQ] & ~secClr) | secIrqEvent;
        // built from the next state so irq moves with its pending bit
        // masked level interrupt
        s_d.irq = (s_d.cfgStatus[`ATR_CFG_PRI_IRQ]
            & s_d.irqMask[`ATR_MASK_PRI])
            | (s_d.secCtrl[`ATR_SEC_IRQ] & s_d.irqMask[`ATR_MASK_SEC]);
        // codes are not monotonic in time, so compare clocks, not codes
        // primary takes the longer setup
        pmClk = setupClks(s_q.pmSetup);
        psClk = setupClks(s_q.psSetup);
        priSetup = (pmClk > psClk) ? pmClk : psClk;
        s_d.pri = chanStep(s_q.pri, priReq, priSetup,
            s_q.pmStrobe, s_q.psStrobe);
        // secondary uses the shared setup field
        s_d.sec = chanStep(s_q.sec, secReq, setupClks(s_q.secCtrl[7:6]),
            s_q.smStrobe, s_q.ssStrobe);
        // read data stands only in the cycle after the strobe
        s_d.rdData = regRdEn ? readReg(s_q, regIdx) : '0;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------

    // synchronous reset of the whole state
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            // setup fields reset to three clocks
            s_q <= STATE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------

    // every output is a state bit
    assign regRdData = s_q.rdData;
    assign priStrobe = s_q.pri.strobe;
    assign priBusy = s_q.pri.busy;
    assign secStrobe = s_q.sec.strobe;
    assign secBusy = s_q.sec.busy;
    assign readAheadDis[2] = s_q.secCtrl[`ATR_SEC_SM_RADIS];
    assign readAheadDis[3] = s_q.secCtrl[`ATR_SEC_SS_RADIS];
    assign readAheadDis[0] = s_q.chanCtrl[`ATR_CTRL_PM_RADIS];
    assign readAheadDis[1] = s_q.chanCtrl[`ATR_CTRL_PS_RADIS];
    assign readAheadLen = s_q.raLen;
    // channel enables from the control register
    assign chanEnable[0] = s_q.chanCtrl[`ATR_CTRL_PRI_EN];
    assign chanEnable[1] = s_q.chanCtrl[`ATR_CTRL_SEC_EN];
    assign irq = s_q.irq;

endmodule : atr_timing_regs
`default_nettype wire

// File: atr_timing_regs_monitor.sv
// assertions on the ports of the strobe timing bank
`timescale 1ns/1ps
`default_nettype none
module atr_timing_regs_monitor
    import atr_pkg::*;
#(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [DATA_W-1:0] regRdData,
    // events and requests
    input wire logic priIrqEvent,
    input wire logic secIrqEvent,
    input wire atr_req_t priReq,
    input wire atr_req_t secReq,
    // outputs
    input wire logic priStrobe,
    input wire logic priBusy,
    input wire logic secStrobe,
    input wire logic secBusy,
    input wire logic [3:0] readAheadDis,
    input wire logic [7:0] readAheadLen,
    input wire logic [1:0] chanEnable,
    input wire logic irq
);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire irqCause = priIrqEvent | secIrqEvent | regWrEn;
    // strobe stays low for the shortest setup
    sequence setupMin;
        !secStrobe ##1 !secStrobe;
    endsequence
    rd_idle_a: assert property (!$past(regRdEn) |-> regRdData == '0)
        else $error("read data not zero when idle");
    ra_reset_a: assert property ($fell(sys_rst) |->
        readAheadLen == 8'h40 && readAheadDis == 4'hf)
        else $error("read-ahead reset values wrong");
    setup_first_a: assert property ($rose(secBusy) |-> setupMin)
        else $error("strobe before setup");
    pri_inside_a: assert property (priStrobe |-> priBusy)
        else $error("strobe outside busy");
    busy_cause_a: assert property ($rose(priBusy) |->
        $past(priReq.start))
        else $error("busy without request");
    recov_after_a: assert property ($fell(priStrobe) |-> priBusy)
        else $error("no recovery after strobe");
    act_max_a: assert property ($rose(secStrobe) |-> ##[1:16] !secStrobe)
        else $error("strobe longer than 16");
    busy_span_a: assert property ($rose(priBusy) |-> ##[4:37] !priBusy)
        else $error("busy length out of range");
    irq_rise_a: assert property ($rose(irq) |->
        $past(irqCause) || $past(irqCause, 2))
        else $error("interrupt without cause");
endmodule : atr_timing_regs_monitor
bind atr_timing_regs atr_timing_regs_monitor #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .priIrqEvent(priIrqEvent),
    .secIrqEvent(secIrqEvent), .priReq(priReq), .secReq(secReq),
    .priStrobe(priStrobe), .priBusy(priBusy), .secStrobe(secStrobe),
    .secBusy(secBusy), .readAheadDis(readAheadDis),
    .readAheadLen(readAheadLen), .chanEnable(chanEnable), .irq(irq));
`default_nettype wire

// File: atr_timing_regs_tb.sv
// self-checking bench for the strobe timing bank
`timescale 1ns/1ps
`default_nettype none
module atr_timing_regs_tb;
    import atr_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] regAddr = '0;
    logic [31:0] regWrData = '0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic priIrqEvent = 1'b0;
    logic secIrqEvent = 1'b0;
    atr_req_t priReq = '0;
    atr_req_t secReq = '0;
    logic [31:0] regRdData;
    logic priStrobe, priBusy, secStrobe, secBusy, irq;
    logic [3:0] readAheadDis;
    logic [7:0] readAheadLen;
    logic [1:0] chanEnable;
    logic [5:0] mS0, mA0, mB0, mS1, mA1, mB1;
    int badCount = 0, checkCount = 0, cycles = 0;
    logic [7:0] rIdx [14] = '{8'h2c, 8'h50, 8'h51, 8'h53, 8'h54, 8'h55,
        8'h56, 8'h57, 8'h58, 8'h59, 8'h5b, 8'h70, 8'h8c, 8'h5a};
    logic [7:0] rVal [14] = '{8'h0, 8'h0, 8'hcc, 8'h80, 8'h0, 8'h80,
        8'h0, 8'h8c, 8'h0, 8'h40, 8'h0, 8'h0, 8'h0, 8'h0};
    logic [7:0] tim [4] = '{8'h21, 8'h00, 8'h3f, 8'hf0};
    logic [1:0] pA [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
    logic [1:0] pB [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
    // ----------------------------------------
    // design, drive models, clock
    // ----------------------------------------
    atr_timing_regs u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regRdData(regRdData), .priIrqEvent(priIrqEvent),
        .secIrqEvent(secIrqEvent), .priReq(priReq), .secReq(secReq),
        .priStrobe(priStrobe), .priBusy(priBusy), .secStrobe(secStrobe),
        .secBusy(secBusy), .readAheadDis(readAheadDis),
        .readAheadLen(readAheadLen), .chanEnable(chanEnable), .irq(irq));
    atr_drive_model u_pri (.ref_clk(ref_clk), .strobe(priStrobe),
        .busy(priBusy), .setupLen(mS0), .actLen(mA0), .busyLen(mB0));
    atr_drive_model u_sec (.ref_clk(ref_clk), .strobe(secStrobe),
        .busy(secBusy), .setupLen(mS1), .actLen(mA1), .busyLen(mB1));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            endSim();
        end
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic endSim;
        $display("checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : endSim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= {i, 2'h0};
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [31:0] exp);
        @(posedge ref_clk);
        regAddr <= {i, 2'h0};
        regRdEn <= 1'b1;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        #1;
        chk(regRdData, exp);
    endtask : rd
    task automatic pulse(input logic sec);
        @(posedge ref_clk);
        secIrqEvent <= sec;
        priIrqEvent <= !sec;
        @(posedge ref_clk);
        secIrqEvent <= 1'b0;
        priIrqEvent <= 1'b0;
    endtask : pulse
    function automatic int setT(input logic [1:0] c);
        return (c == 2'h0) ? 4 : (c == 2'h1) ? 2 : (c == 2'h2) ? 3 : 5;
    endfunction : setT
    // start held a second cycle with the other drive: must be ignored
    task automatic strobe(input int ch, input logic sel, input int s,
        input logic [7:0] t);
        int a, r;
        a = (t[7:4] == 4'h0) ? 16 : int'(t[7:4]);
        r = (t[3:0] == 4'h0) ? 16 : (t[3:0] == 4'hf) ? 1 : int'(t[3:0]) + 1;
        for (int n = 0; n < 3; n++) begin
            @(posedge ref_clk);
            if (ch == 1) secReq <= '{start: n < 2, drvSel: sel ^ (n == 1)};
            else priReq <= '{start: n < 2, drvSel: sel ^ (n == 1)};
        end
        for (int n = 0; n < 60; n++) begin
            @(posedge ref_clk);
            #1;
            if (!(ch == 1 ? secBusy : priBusy)) break;
        end
        chk({26'h0, (ch == 1) ? mS1 : mS0}, s);
        chk({26'h0, (ch == 1) ? mA1 : mA0}, a);
        chk({26'h0, (ch == 1) ? mB1 : mB0}, s + a + r);
    endtask : strobe
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 14; i++) rd(rIdx[i], {24'h0, rVal[i]});
        chk(readAheadDis, 4'hf);
        chk(chanEnable, 2'h3);
        $display("test reset values done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h57, {k[1:0], 6'h0c});
            wr(8'h58, tim[k]);
            wr(8'h5b, ~tim[k]);
            strobe(1, 1'b0, setT(k[1:0]), tim[k]);
            strobe(1, 1'b1, setT(k[1:0]), ~tim[k]);
        end
        $display("test secondary strobes done");
        wr(8'h54, 8'h12);
        wr(8'h56, 8'h34);
        for (int j = 0; j < 4; j++) begin
            wr(8'h53, {pA[j], 6'h0});
            wr(8'h55, {pB[j], 6'h0});
            strobe(0, j[0], 4 + (j < 2), j[0] ? 8'h34 : 8'h12);
        end
        $display("test primary strobes done");
        wr(8'h70, 32'h3);
        pulse(1'b1);
        wr(8'h57, 8'hcc);
        rd(8'h57, 32'hdc);
        chk(irq, 1'b1);
        wr(8'h57, 8'hdc);
        rd(8'h57, 32'hcc);
        chk(irq, 1'b0);
        pulse(1'b0);
        rd(8'h50, 32'h4);
        chk(irq, 1'b1);
        wr(8'h70, 32'h2);
        rd(8'h70, 32'h2);
        chk(irq, 1'b0);
        wr(8'h50, 32'h4);
        rd(8'h50, 32'h0);
        $display("test interrupts done");
        wr(8'h51, 8'h0c);
        rd(8'h51, 32'h0c);
        chk(readAheadDis, 4'hc);
        wr(8'h59, 8'h7f);
        #1;
        chk(readAheadLen, 8'h7f);
        wr(8'h8c, 32'h1234abcd);
        rd(8'h2c, 32'h1234abcd);
        wr(8'h2c, 32'h55667788);
        rd(8'h8c, 32'h55667788);
        $display("test config and shadow done");
        endSim();
    end
endmodule : atr_timing_regs_tb
`default_nettype wire
